/* File: logic/scr_regs.sv */
`timescale 1ns/100ps
module scr_regs #(
  parameter int WDT_SHORT = scr_pkg::WDT_SHORT_CYC,
  parameter int WDT_LONG  = scr_pkg::WDT_LONG_CYC
) (
  // System clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rstn,
  // Register access from serial engine, link clock domain
  input  wire logic               i_link_clk,
  input  wire logic               i_lk_wr_stb,
  input  wire logic               i_lk_rd_stb,
  input  wire logic [7:0]         i_lk_addr,
  input  wire logic [7:0]         i_lk_wdata,
  output logic      [7:0]         o_lk_rdata,
  output logic                    o_lk_ack,
  output logic                    o_lk_busy,
  // Events from datapath
  input  wire logic               i_evt_fwm,
  input  wire logic               i_evt_full,
  input  wire logic               i_evt_drdy,
  // Nonvolatile defaults and I2C bus activity pin
  input  wire logic               i_nvm_wdt_en,
  input  wire logic               i_nvm_wdt_sel,
  input  wire logic               i_i2c_bus_busy,
  // Interrupt pin
  output logic                    o_irq_out,
  output logic                    o_irq_oe,
  output logic                    o_irq_drive_setting,
  // Configuration outputs
  output logic                    o_three_wire_select,
  output logic                    o_i2c_wdt_expire,
  output logic                    o_press_en,
  output logic                    o_temp_en,
  output scr_pkg::scr_mode_t      o_pwr_mode,
  output logic      [5:0]         o_press_samples,
  output logic      [5:0]         o_thermo_sample_count,
  output logic      [4:0]         o_odr_effective,
  output logic      [17:0]        o_subdiv_factor,
  output logic      [19:0]        o_sample_period_ms,
  output logic      [6:0]         o_iir_coef,
  // Commands
  output logic                    o_fifo_flush,
  output logic                    o_soft_reset
);
  import scr_pkg::*;
  // Link domain: capture request, toggle across
  logic       lk_tgl_r, lk_busy_r, lk_we_r, lk_done;
  logic [7:0] lk_addr_r, lk_wdata_r, rdata_r;
  logic       ack_s1_r, ack_s2_r, ack_s3_r, ack_tgl_r;
  assign lk_done   = ack_s2_r ^ ack_s3_r;
  assign o_lk_busy = lk_busy_r;
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lk_tgl_r   <= 1'b0;
      lk_busy_r  <= 1'b0;
      lk_we_r    <= 1'b0;
      lk_addr_r  <= 8'h00;
      lk_wdata_r <= 8'h00;
    end else if (!lk_busy_r && (i_lk_wr_stb || i_lk_rd_stb)) begin
      lk_tgl_r   <= ~lk_tgl_r;
      lk_busy_r  <= 1'b1;
      lk_we_r    <= i_lk_wr_stb;
      lk_addr_r  <= i_lk_addr;
      lk_wdata_r <= i_lk_wdata;
    end else if (lk_done) begin
      lk_busy_r  <= 1'b0;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_s1_r   <= 1'b0;
      ack_s2_r   <= 1'b0;
      ack_s3_r   <= 1'b0;
      o_lk_ack   <= 1'b0;
      o_lk_rdata <= 8'h00;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      o_lk_ack <= lk_done;
      // Read data is held still in the system domain until the ack arrives
      if (lk_done) begin
        o_lk_rdata <= rdata_r;
      end
    end
  end

  // System domain: request synchroniser
  logic req_s1_r, req_s2_r, req_s3_r;
  logic req_pulse, wr_acc, rd_acc;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_s1_r  <= 1'b0;
      req_s2_r  <= 1'b0;
      req_s3_r  <= 1'b0;
      ack_tgl_r <= 1'b0;
    end else begin
      req_s1_r <= lk_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      if (req_pulse) begin
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end
  assign req_pulse = req_s2_r ^ req_s3_r;
  assign wr_acc    = req_pulse && lk_we_r;
  assign rd_acc    = req_pulse && !lk_we_r;
  // Command decoder
  scr_cmd_st_t cmd_st_r;
  logic [2:0]  cmd_cnt_r;
  logic        cmd_go, flush_go, srst_go, cmd_rdy;
  assign cmd_go   = wr_acc && (lk_addr_r == ADDR_CMD) && (cmd_st_r == SCR_CMD_IDLE);
  // RL21 Unknown codes ignored
  assign flush_go = cmd_go && (lk_wdata_r == CMD_FLUSH);
  assign srst_go  = cmd_go && (lk_wdata_r == CMD_SRST);
  // RL22 Ready bit
  assign cmd_rdy  = (cmd_st_r == SCR_CMD_IDLE);
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmd_st_r  <= SCR_CMD_IDLE;
      cmd_cnt_r <= 3'h0;
    end else begin
      case (cmd_st_r)
        SCR_CMD_IDLE: begin
          if (flush_go || srst_go) begin
            cmd_st_r  <= SCR_CMD_BUSY;
            cmd_cnt_r <= 3'(CMD_BUSY_CYC - 1);
          end
        end
        SCR_CMD_BUSY: begin
          if (cmd_cnt_r == 3'h0) begin
            cmd_st_r <= SCR_CMD_IDLE;
          end else begin
            cmd_cnt_r <= cmd_cnt_r - 3'h1;
          end
        end
        default: cmd_st_r <= SCR_CMD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fifo_flush <= 1'b0;
      o_soft_reset <= 1'b0;
    end else begin
      // RL19 Flush strobe
      o_fifo_flush <= flush_go;
      // RL20 Soft reset strobe
      o_soft_reset <= srst_go;
    end
  end

  // Configuration registers
  logic [7:0] int_cfg_r, pwr_ctl_r, osr_cfg_r, odr_sel_r, filt_cfg_r;
  logic       three_w_r, wdt_en_r, wdt_sel_r, nvm_loaded_r;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      int_cfg_r  <= RST_INT_CFG;
      pwr_ctl_r  <= RST_PWR_CTL;
      osr_cfg_r  <= RST_OSR_CFG;
      odr_sel_r  <= RST_ODR_SEL;
      filt_cfg_r <= RST_FILT_CFG;
      three_w_r  <= 1'b0;
    // RL20 Defaults restored
    end else if (srst_go) begin
      int_cfg_r  <= RST_INT_CFG;
      pwr_ctl_r  <= RST_PWR_CTL;
      osr_cfg_r  <= RST_OSR_CFG;
      odr_sel_r  <= RST_ODR_SEL;
      filt_cfg_r <= RST_FILT_CFG;
      three_w_r  <= 1'b0;
    end else if (wr_acc) begin
      case (lk_addr_r)
        ADDR_INT_CFG:  int_cfg_r  <= lk_wdata_r;
        ADDR_PWR_CTL:  pwr_ctl_r  <= lk_wdata_r;
        ADDR_OSR_CFG:  osr_cfg_r  <= lk_wdata_r;
        ADDR_ODR_SEL:  odr_sel_r  <= lk_wdata_r;
        ADDR_FILT_CFG: filt_cfg_r <= lk_wdata_r;
        ADDR_SIF_CFG:  three_w_r  <= lk_wdata_r[B_THREE_W];
        default:       three_w_r  <= three_w_r;
      endcase
    end
  end

  // RL7 Nonvolatile defaults loaded after reset release and on soft reset
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nvm_loaded_r <= 1'b0;
      wdt_en_r     <= 1'b0;
      wdt_sel_r    <= 1'b0;
    end else if (!nvm_loaded_r || srst_go) begin
      nvm_loaded_r <= 1'b1;
      wdt_en_r     <= i_nvm_wdt_en;
      wdt_sel_r    <= i_nvm_wdt_sel;
    end else if (wr_acc && (lk_addr_r == ADDR_SIF_CFG)) begin
      wdt_en_r     <= lk_wdata_r[B_WDT_EN];
      wdt_sel_r    <= lk_wdata_r[B_WDT_SEL];
    end
  end

  // I2C watchdog: counts while the bus pin shows a transfer stuck
  logic        bus_s1_r, bus_s2_r;
  logic [23:0] wdt_cnt_r, wdt_lim;
  // RL8 RL9 Timeout select
  assign wdt_lim = wdt_sel_r ? 24'(WDT_LONG - 1) : 24'(WDT_SHORT - 1);
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_s1_r         <= 1'b0;
      bus_s2_r         <= 1'b0;
      wdt_cnt_r        <= 24'h00_0000;
      o_i2c_wdt_expire <= 1'b0;
    end else begin
      bus_s1_r         <= i_i2c_bus_busy;
      bus_s2_r         <= bus_s1_r;
      o_i2c_wdt_expire <= 1'b0;
      // RL7 Watchdog gated by enable
      if (!wdt_en_r || !bus_s2_r) begin
        wdt_cnt_r <= 24'h00_0000;
      end else if (wdt_cnt_r >= wdt_lim) begin
        wdt_cnt_r        <= 24'h00_0000;
        o_i2c_wdt_expire <= 1'b1;
      end else begin
        wdt_cnt_r <= wdt_cnt_r + 24'h00_0001;
      end
    end
  end

  // Interrupt status
  logic [7:0] int_sts_r;
  logic [7:0] evt_gated;
  logic       rd_int_sts, rd_event, por_r;
  assign rd_int_sts = rd_acc && (lk_addr_r == ADDR_INT_STAT);
  assign rd_event   = rd_acc && (lk_addr_r == ADDR_EVENT);
  always_comb begin
    evt_gated = 8'h00;
    // RL3 Watermark gate
    evt_gated[B_ST_FWM]  = i_evt_fwm  && int_cfg_r[B_FWM_EN];
    // RL4 Full gate
    evt_gated[B_ST_FULL] = i_evt_full && int_cfg_r[B_FULL_EN];
    // RL5 Data-ready gate
    evt_gated[B_ST_DRDY] = i_evt_drdy && int_cfg_r[B_DRDY_EN];
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      int_sts_r <= 8'h00;
    end else if (srst_go) begin
      int_sts_r <= 8'h00;
    // RL2 Latched: held until read, new event beats the clear
    end else if (int_cfg_r[B_IRQ_LATCH]) begin
      // RL23 Clear on read
      int_sts_r <= (rd_int_sts ? 8'h00 : int_sts_r) | evt_gated;
    end else begin
      int_sts_r <= evt_gated;
    end
  end

  // RL24 Power-on flag
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      por_r <= 1'b1;
    end else if (srst_go) begin
      por_r <= 1'b1;
    end else if (rd_event) begin
      por_r <= 1'b0;
    end
  end

  // RL1 Pin polarity and output stage
  logic irq_any;
  assign irq_any  = |int_sts_r;
  assign o_irq_oe = !int_cfg_r[B_IRQ_TYPE] || !o_irq_out;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_out <= 1'b1;
    end else begin
      o_irq_out <= int_cfg_r[B_IRQ_LEVEL] ? irq_any : !irq_any;
    end
  end

  // Read mux; status is sampled here so the link never sees a moving value
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= RD_ZERO;
    end else if (rd_acc) begin
      case (lk_addr_r)
        ADDR_STATUS:   rdata_r <= 8'(cmd_rdy) << B_CMD_RDY;
        ADDR_EVENT:    rdata_r <= 8'(por_r) << B_POR;
        ADDR_INT_STAT: rdata_r <= int_sts_r;
        ADDR_INT_CFG:  rdata_r <= int_cfg_r;
        ADDR_SIF_CFG:  rdata_r <= {5'h00, wdt_sel_r, wdt_en_r, three_w_r};
        ADDR_PWR_CTL:  rdata_r <= pwr_ctl_r;
        ADDR_OSR_CFG:  rdata_r <= osr_cfg_r;
        ADDR_ODR_SEL:  rdata_r <= odr_sel_r;
        ADDR_FILT_CFG: rdata_r <= filt_cfg_r;
        // RL18 Command reads zero
        ADDR_CMD:      rdata_r <= RD_ZERO;
        default:       rdata_r <= RD_ZERO;
      endcase
    end
  end

  // Decoded configuration
  logic [2:0] osr_p, osr_t;
  logic [1:0] mode_f;
  assign osr_p = osr_cfg_r[B_OSRP_LO +: 3];
  assign osr_t = osr_cfg_r[B_OSRT_LO +: 3];
  assign mode_f = pwr_ctl_r[B_MODE_LO +: 2];
  always_comb begin
    o_irq_drive_setting = int_cfg_r[B_IRQ_DRIVE];
    // RL6 Wire count
    o_three_wire_select = three_w_r;
    // RL10 Sensor enables
    o_press_en = pwr_ctl_r[B_PRESS_EN];
    o_temp_en  = pwr_ctl_r[B_TEMP_EN];
    // RL11 Power mode
    case (mode_f)
      2'b00:   o_pwr_mode = SCR_MODE_SLEEP;
      2'b11:   o_pwr_mode = SCR_MODE_NORMAL;
      default: o_pwr_mode = SCR_MODE_FORCED;
    endcase
    // RL12 Pressure samples; codes above the top clamp to it
    o_press_samples = 6'h01 << ((osr_p > OSR_MAX) ? OSR_MAX : osr_p);
    // RL13 Temperature samples
    o_thermo_sample_count = 6'h01 << ((osr_t > OSR_MAX) ? OSR_MAX : osr_t);
    // RL15 Rate saturation
    o_odr_effective = (odr_sel_r[4:0] > ODR_MAX) ? ODR_MAX : odr_sel_r[4:0];
    // RL14 Subdivision factor
    o_subdiv_factor = 18'h0_0001 << o_odr_effective;
    // RL16 Normal-mode period
    o_sample_period_ms = 20'(PERIOD_MS0) << o_odr_effective;
    // RL17 Filter coefficient
    o_iir_coef = 7'((8'h01 << filt_cfg_r[B_IIR_LO +: 3]) - 8'h01);
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_cmd_rd_zero;
    rd_acc && (lk_addr_r == ADDR_CMD) |=> (rdata_r == RD_ZERO);
  endproperty
  a_cmd_rd_zero: assert property (p_cmd_rd_zero) // RL18
    else $error("command register read not zero");
  property p_flush;
    flush_go |=> o_fifo_flush && !o_soft_reset ##1 !o_fifo_flush;
  endproperty
  a_flush: assert property (p_flush) // RL19
    else $error("flush strobe wrong");
  property p_srst;
    srst_go |=> o_soft_reset && (int_cfg_r == RST_INT_CFG) && (odr_sel_r == RST_ODR_SEL)
      && (pwr_ctl_r == RST_PWR_CTL) && por_r;
  endproperty
  a_srst: assert property (p_srst) // RL20
    else $error("soft reset did not restore defaults");
  property p_nop;
    wr_acc && (lk_addr_r == ADDR_CMD) && (lk_wdata_r != CMD_FLUSH)
      && (lk_wdata_r != CMD_SRST) |=> !o_fifo_flush && !o_soft_reset;
  endproperty
  a_nop: assert property (p_nop) // RL21
    else $error("unknown command acted");
  property p_cmd_rdy;
    flush_go || srst_go |=> (!cmd_rdy)[*4] ##1 cmd_rdy;
  endproperty
  a_cmd_rdy: assert property (p_cmd_rdy) // RL22
    else $error("command ready timing wrong");
  property p_odr_sat;
    (odr_sel_r[4:0] > ODR_MAX) |-> (o_odr_effective == ODR_MAX)
      && (o_sample_period_ms == 20'(PERIOD_MS0) << ODR_MAX);
  endproperty
  a_odr_sat: assert property (p_odr_sat) // RL15
    else $error("rate field not saturated");
  property p_fwm_gate;
    $rose(int_sts_r[B_ST_FWM]) |-> $past(int_cfg_r[B_FWM_EN]);
  endproperty
  a_fwm_gate: assert property (p_fwm_gate) // RL3
    else $error("watermark status set while disabled");
  property p_latch_hold;
    int_cfg_r[B_IRQ_LATCH] && $past(int_cfg_r[B_IRQ_LATCH]) && !$past(rd_int_sts)
      && !$past(srst_go) && $past(int_sts_r[B_ST_FULL]) |-> int_sts_r[B_ST_FULL];
  endproperty
  a_latch_hold: assert property (p_latch_hold) // RL2
    else $error("latched status lost");
  property p_pin_level;
    ##1 o_irq_out == ($past(int_cfg_r[B_IRQ_LEVEL]) == ($past(int_sts_r) != 8'h00));
  endproperty
  a_pin_level: assert property (p_pin_level) // RL1
    else $error("interrupt pin polarity wrong");
  property p_por_clear;
    rd_event && !srst_go |=> !por_r;
  endproperty
  a_por_clear: assert property (p_por_clear) // RL24
    else $error("power-on flag not cleared on read");
endmodule

/* File: logic/scr_pkg.sv */
// Notes on behaviour
// RL1: Irq pin push-pull/open-drain, selectable polarity
// RL2: Latch bit holds interrupts on pin, status
// RL3: Watermark interrupt passes only when enabled
// RL4: Full interrupt passes only when enabled
// RL5: Data-ready interrupt passes only when enabled
// RL6: Config bit picks four- or three-wire SPI
// RL7: Nonvolatile-backed bit enables I2C watchdog
// RL8: Watchdog timeout is 1.25 ms or 40 ms
// RL9: Select zero short timeout, one long
// RL10: Separate pressure and temperature enable bits
// RL11: Mode 00 sleep, 01/10 forced, 11 normal
// RL12: Pressure oversampling codes 0-5 give 1..32
// RL13: Temperature oversampling upper field 1..32 samples
// RL14: Rate field gives subdivision two to value
// RL15: Rate values above 17 saturate at 17
// RL16: Normal period 5 ms, doubling per step
// RL17: Filter code selects coefficient 0..127
// RL18: Command register writes commands, reads zero
// RL19: Flush command empties FIFO, keeps configuration
// RL20: Soft reset restores all user defaults
// RL21: Other command codes cause no action
// RL22: Command-ready bit low while command executes
// RL23: Interrupt status reports events, clears on read; code clears on read only with the latch bit set
// RL24: Power-on flag set after reset, clear-on-read
package scr_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS    = 8'h03;
  localparam logic [7:0] ADDR_EVENT     = 8'h10;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h11;
  localparam logic [7:0] ADDR_INT_CFG   = 8'h19;
  localparam logic [7:0] ADDR_SIF_CFG   = 8'h1a;
  localparam logic [7:0] ADDR_PWR_CTL   = 8'h1b;
  localparam logic [7:0] ADDR_OSR_CFG   = 8'h1c;
  localparam logic [7:0] ADDR_ODR_SEL   = 8'h1d;
  localparam logic [7:0] ADDR_FILT_CFG  = 8'h1f;
  localparam logic [7:0] ADDR_CMD       = 8'h7e;
  // Reset values
  localparam logic [7:0] RST_INT_CFG    = 8'h00;
  localparam logic [7:0] RST_PWR_CTL    = 8'h00;
  localparam logic [7:0] RST_OSR_CFG    = 8'h00;
  localparam logic [7:0] RST_ODR_SEL    = 8'h00;
  localparam logic [7:0] RST_FILT_CFG   = 8'h00;
  localparam logic [7:0] RD_ZERO        = 8'h00;
  // Field positions
  localparam int B_IRQ_TYPE  = 0;
  localparam int B_IRQ_LEVEL = 1;
  localparam int B_IRQ_LATCH = 2;
  localparam int B_FWM_EN    = 3;
  localparam int B_FULL_EN   = 4;
  localparam int B_IRQ_DRIVE = 5;
  localparam int B_DRDY_EN   = 6;
  localparam int B_THREE_W   = 0;
  localparam int B_WDT_EN    = 1;
  localparam int B_WDT_SEL   = 2;
  localparam int B_PRESS_EN  = 0;
  localparam int B_TEMP_EN   = 1;
  localparam int B_MODE_LO   = 4;
  localparam int B_OSRP_LO   = 0;
  localparam int B_OSRT_LO   = 3;
  localparam int B_IIR_LO    = 1;
  localparam int B_CMD_RDY   = 4;
  localparam int B_POR       = 0;
  localparam int B_ST_FWM    = 0;
  localparam int B_ST_FULL   = 1;
  localparam int B_ST_DRDY   = 3;
  // Commands
  localparam logic [7:0] CMD_FLUSH = 8'hb0;
  localparam logic [7:0] CMD_SRST  = 8'hb6;
  // Field limits
  localparam logic [4:0] ODR_MAX     = 5'h11;
  localparam logic [2:0] OSR_MAX     = 3'h5;
  localparam logic [4:0] PERIOD_MS0  = 5'h05;
  // Timing
  localparam int SYS_PERIOD_PS = 4000;
  localparam int WDT_SHORT_US  = 1250;
  localparam int WDT_LONG_MS   = 40;
  // Cycles per unit first, so the products stay inside a 32-bit int
  localparam int WDT_SHORT_CYC = WDT_SHORT_US * (1000 * 1000 / SYS_PERIOD_PS);
  localparam int WDT_LONG_CYC  = WDT_LONG_MS * 1000 * (1000 * 1000 / SYS_PERIOD_PS);
  localparam int CMD_BUSY_CYC  = 4;
  typedef enum logic [1:0] {
    SCR_MODE_SLEEP  = 2'b00,
    SCR_MODE_FORCED = 2'b01,
    SCR_MODE_NORMAL = 2'b11
  } scr_mode_t;
  typedef enum logic [1:0] {
    SCR_CMD_IDLE = 2'b00,
    SCR_CMD_BUSY = 2'b01
  } scr_cmd_st_t;
endpackage

/* File: verification/scr_host.sv */
`timescale 1ns/100ps
module scr_host (
  // Link clock and register strobes
  output logic       o_link_clk,
  output logic       o_wr_stb,
  output logic       o_rd_stb,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  // Answer from the register block
  input  wire logic  i_ack
);
  // Free-running link clock, phase unrelated to the system clock
  initial begin
    o_link_clk = 1'b0;
    o_wr_stb   = 1'b0;
    o_rd_stb   = 1'b0;
    o_addr     = 8'h00;
    o_wdata    = 8'h00;
    #5.3;
    forever #32 o_link_clk = ~o_link_clk;
  end

  // One outstanding access; returns once the acknowledge is sampled
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic ok);
    int n;
    @(posedge o_link_clk);
    #1;
    o_wr_stb = wr;
    o_rd_stb = ~wr;
    o_addr   = a;
    o_wdata  = d;
    @(posedge o_link_clk);
    #1;
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    // Released lines must not keep looking valid
    o_addr   = ~a;
    o_wdata  = ~d;
    ok = 1'b0;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge o_link_clk);
      ok = (i_ack === 1'b1);
    end
  endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb;
  import scr_pkg::*;
  localparam int WS = 20;
  localparam int WL = 50;
  logic              i_sys_clk;
  logic              i_rstn;
  logic              lk;
  logic              wr;
  logic              rd;
  logic [7:0]        addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic              ack;
  logic              busy;
  logic              fwm;
  logic              full;
  logic              drdy;
  logic              i2c_busy;
  logic              nvm_en;
  logic              nvm_sel;
  logic              irq;
  logic              irq_oe;
  logic              irq_ds;
  logic              three_w;
  logic              wdt_exp;
  logic              p_en;
  logic              t_en;
  scr_mode_t         mode;
  logic [5:0]        p_smp;
  logic [5:0]        t_smp;
  logic [4:0]        odr_eff;
  logic [17:0]       subdiv;
  logic [19:0]       period;
  logic [6:0]        iir;
  logic              flush;
  logic              srst;
  logic [15:0]       exp_q[$];
  int                err_count;
  int                cmp_count;
  int                flush_n;
  int                srst_n;

  scr_host u_scr_host (
    .o_link_clk (lk),
    .o_wr_stb   (wr),
    .o_rd_stb   (rd),
    .o_addr     (addr),
    .o_wdata    (wdata),
    .i_ack      (ack)
  );

  scr_regs #(.WDT_SHORT(WS), .WDT_LONG(WL)) u_scr_regs (
    .i_sys_clk             (i_sys_clk),
    .i_rstn                (i_rstn),
    .i_link_clk            (lk),
    .i_lk_wr_stb           (wr),
    .i_lk_rd_stb           (rd),
    .i_lk_addr             (addr),
    .i_lk_wdata            (wdata),
    .o_lk_rdata            (rdata),
    .o_lk_ack              (ack),
    .o_lk_busy             (busy),
    .i_evt_fwm             (fwm),
    .i_evt_full            (full),
    .i_evt_drdy            (drdy),
    .i_nvm_wdt_en          (nvm_en),
    .i_nvm_wdt_sel         (nvm_sel),
    .i_i2c_bus_busy        (i2c_busy),
    .o_irq_out             (irq),
    .o_irq_oe              (irq_oe),
    .o_irq_drive_setting   (irq_ds),
    .o_three_wire_select   (three_w),
    .o_i2c_wdt_expire      (wdt_exp),
    .o_press_en            (p_en),
    .o_temp_en             (t_en),
    .o_pwr_mode            (mode),
    .o_press_samples       (p_smp),
    .o_thermo_sample_count (t_smp),
    .o_odr_effective       (odr_eff),
    .o_subdiv_factor       (subdiv),
    .o_sample_period_ms    (period),
    .o_iir_coef            (iir),
    .o_fifo_flush          (flush),
    .o_soft_reset          (srst)
  );

  always #2 i_sys_clk = ~i_sys_clk;

  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Mask zero marks a write; reads compare only the masked bits
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] m);
    logic ok;
    exp_q.push_back({m, d & m});
    u_scr_host.access(w, a, d, ok);
    check(20'(ok), 20'h1);
    if (!ok) results();
  endtask

  task automatic sys_wait(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // Read data is judged in the cycle the acknowledge stands
  always @(posedge lk) begin
    if (ack === 1'b1) begin
      check(20'(busy), 20'h0);
      if (exp_q.size() == 0) check(20'h0, 20'h1);
      else if (exp_q[0][15:8] != 8'h00)
        check(20'(rdata & exp_q[0][15:8]), 20'(exp_q[0][7:0]));
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  always @(posedge i_sys_clk) begin
    if (flush === 1'b1) flush_n++;
    if (srst === 1'b1) srst_n++;
  end

  task automatic defaults();
    xfer(1'b0, ADDR_INT_CFG, RST_INT_CFG, 8'h7f);
    xfer(1'b0, ADDR_SIF_CFG, {5'h00, nvm_sel, nvm_en, 1'b0}, 8'h07);
    xfer(1'b0, ADDR_PWR_CTL, RST_PWR_CTL, 8'h33);
    xfer(1'b0, ADDR_OSR_CFG, RST_OSR_CFG, 8'h3f);
    xfer(1'b0, ADDR_ODR_SEL, RST_ODR_SEL, 8'h1f);
    xfer(1'b0, ADDR_FILT_CFG, RST_FILT_CFG, 8'h0e);
    xfer(1'b0, ADDR_EVENT, 8'h01, 8'h01);
    xfer(1'b0, ADDR_EVENT, 8'h00, 8'h01);
  endtask

  // Holds bus activity and counts system cycles to the expiry pulse
  task automatic wdt(input logic [7:0] cfg, input int lo, input int hi);
    int n;
    xfer(1'b1, ADDR_SIF_CFG, cfg, 8'h00);
    xfer(1'b0, ADDR_SIF_CFG, cfg, 8'h07);
    check(20'(three_w), 20'(cfg[0]));
    sys_wait(1);
    i2c_busy = 1'b1;
    for (n = 0; n < 120 && wdt_exp !== 1'b1; n++) sys_wait(1);
    check(20'(n >= lo && n <= hi), 20'h1);
    i2c_busy = 1'b0;
    sys_wait(4);
  endtask

  initial begin
    int i;
    int e;
    logic [2:0] t;
    i_sys_clk = 1'b0;
    i_rstn    = 1'b0;
    fwm       = 1'b0;
    full      = 1'b0;
    drdy      = 1'b0;
    i2c_busy  = 1'b0;
    err_count = 0;
    cmp_count = 0;
    flush_n   = 0;
    srst_n    = 0;
    void'($urandom(92));
    nvm_en    = 1'($urandom);
    nvm_sel   = 1'($urandom);
    // Reset must span edges of the slower link clock as well
    repeat (5) @(posedge lk);
    #1;
    i_rstn = 1'b1;
    repeat (3) @(posedge lk);
    defaults();
    xfer(1'b0, ADDR_STATUS, 8'h10, 8'h10);
    xfer(1'b0, ADDR_CMD, RD_ZERO, 8'hff);
    xfer(1'b0, 8'h20, 8'h00, 8'hff);
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, ADDR_PWR_CTL, {2'b00, 2'(i), 2'b00, 2'(i)}, 8'h00);
      check(20'(mode), (i == 2) ? 20'h1 : 20'(i));
      check(20'({t_en, p_en}), 20'(i));
    end
    for (i = 0; i < 8; i++) begin
      t = 3'($urandom);
      xfer(1'b1, ADDR_OSR_CFG, {2'b00, t, 3'(i)}, 8'h00);
      xfer(1'b1, ADDR_FILT_CFG, {4'h0, 3'(i), 1'b0}, 8'h00);
      xfer(1'b0, ADDR_OSR_CFG, {2'b00, t, 3'(i)}, 8'h3f);
      check(20'(p_smp), 20'(1) << ((i > 5) ? 5 : i));
      check(20'(t_smp), 20'(1) << ((t > 5) ? 5 : t));
      check(20'(iir), (20'(1) << i) - 20'(1));
    end
    for (i = 0; i < 32; i++) begin
      xfer(1'b1, ADDR_ODR_SEL, {3'($urandom), 5'(i)}, 8'h00);
      e = (i > 17) ? 17 : i;
      check(20'(odr_eff), 20'(e));
      check(20'(subdiv), 20'(1) << e);
      check(period, 20'(5) << e);
    end
    wdt(8'h03, WS, WS + 5);
    wdt(8'h06, WL, WL + 5);
    wdt(8'h04, 120, 120);
    xfer(1'b1, ADDR_INT_CFG, 8'h62, 8'h00);
    check(20'(irq_ds), 20'h1);
    sys_wait(1);
    fwm  = 1'b1;
    full = 1'b1;
    drdy = 1'b1;
    sys_wait(4);
    check(20'({irq, irq_oe}), 20'h3);
    xfer(1'b0, ADDR_INT_STAT, 8'h08, 8'h0b);
    fwm  = 1'b0;
    full = 1'b0;
    drdy = 1'b0;
    sys_wait(4);
    check(20'({irq, irq_oe}), 20'h1);
    xfer(1'b1, ADDR_INT_CFG, 8'h1d, 8'h00);
    check(20'(irq_ds), 20'h0);
    sys_wait(3);
    check(20'({irq, irq_oe}), 20'h2);
    full = 1'b1;
    sys_wait(1);
    full = 1'b0;
    drdy = 1'b1;
    sys_wait(1);
    drdy = 1'b0;
    sys_wait(4);
    check(20'({irq, irq_oe}), 20'h1);
    xfer(1'b0, ADDR_INT_STAT, 8'h02, 8'h0b);
    xfer(1'b0, ADDR_INT_STAT, 8'h00, 8'h0b);
    sys_wait(4);
    check(20'({irq, irq_oe}), 20'h2);
    fwm = 1'b1;
    sys_wait(1);
    fwm = 1'b0;
    sys_wait(4);
    xfer(1'b0, ADDR_INT_STAT, 8'h01, 8'h0b);
    xfer(1'b1, ADDR_PWR_CTL, 8'h31, 8'h00);
    xfer(1'b1, ADDR_CMD, CMD_FLUSH, 8'h00);
    sys_wait(8);
    check(20'(flush_n), 20'h1);
    xfer(1'b0, ADDR_PWR_CTL, 8'h31, 8'h33);
    xfer(1'b1, ADDR_CMD, 8'h55, 8'h00);
    xfer(1'b1, ADDR_CMD, 8'h00, 8'h00);
    sys_wait(8);
    check(20'({flush_n[3:0], srst_n[3:0]}), 20'h10);
    // New nonvolatile values must be picked up by the soft reset
    nvm_en  = ~nvm_en;
    nvm_sel = ~nvm_sel;
    xfer(1'b0, ADDR_STATUS, 8'h10, 8'h10);
    xfer(1'b1, ADDR_CMD, CMD_SRST, 8'h00);
    sys_wait(8);
    check(20'(srst_n), 20'h1);
    defaults();
    results();
  end
endmodule
